//--- src/async_serial_receiver.sv
// Asynchronous serial receiver with two-deep receive queue and register port.
// Assumes one 20 MHz clock, a single-cycle register master, rxPin from outside.
//
// The implementer's own choice: the address-and-strobe port.
`include "serial_rx_defines.svh"
`default_nettype none
module async_serial_receiver (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic [7:0]             addr,
  input  wire logic [7:0]             wrData,
  input  wire logic                   wrStrobe,
  input  wire logic                   rdStrobe,
  output logic      [7:0]             rdData,
  input  wire logic                   rxPin,
  output logic                        irq
);
  import serial_rx_pkg::*;

  typedef struct packed {
    reg_byte_t      intCtrl;
    reg_byte_t      pie;
    reg_byte_t      rcCtrl;
    reg_byte_t      txStatus;
    reg_byte_t      txData;
    reg_byte_t      baud;
    reg_byte_t      rdData;
    logic [2:0]     rxSync;
    rx_state_t      state;
    logic [7:0]     baudCnt;
    logic [3:0]     tickCnt;
    logic [3:0]     bitCnt;
    logic [8:0]     shiftReg;
    rx_entry_t [1:0] queue;
    logic [1:0]     count;
    logic           overrun;
    logic           rxLevel;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic   tick;
  logic   asyncOn;
  logic   recvOn;
  logic   popReq;
  logic   stopEvent;
  logic   accept;
  rx_entry_t head;

  assign head    = cur.queue[0];
  assign asyncOn = cur.rcCtrl[`BIT_SERIAL_PORT_EN] && !cur.txStatus[`BIT_SYNC_MODE];
  assign recvOn  = asyncOn && cur.rcCtrl[`BIT_CONT_RECEIVE_EN];
  assign popReq  = rdStrobe && addr == `ADDR_RECEIVE_DATA && cur.count != 2'h0;
  assign irq     = cur.count != 2'h0 && cur.pie[`BIT_RECEIVE_FLAG]
                   && cur.intCtrl[`BIT_GLOBAL_IE] && cur.intCtrl[`BIT_PERIPH_IE];
  assign rdData  = cur.rdData;

  always_comb begin
    logic [7:0] status;
    logic       ninthOn;
    logic       isAddr;
    status   = 8'h00;
    ninthOn  = cur.rcCtrl[`BIT_NINE_BIT_EN];
    isAddr   = 1'b0;
    next_cur = cur;
    tick     = 1'b0;
    stopEvent = 1'b0;
    accept   = 1'b0;

    // Three-stage synchroniser, level updates when stages two and three agree
    next_cur.rxSync = {cur.rxSync[1:0], rxPin};
    if (cur.rxSync[2] == cur.rxSync[1]) begin
      next_cur.rxLevel = cur.rxSync[2];
    end

    // Divider for sixteen-times bit rate enable
    if (!recvOn || cur.baudCnt == 8'h00) begin
      next_cur.baudCnt = cur.baud;
      tick = recvOn;
    end else begin
      next_cur.baudCnt = cur.baudCnt - 8'h01;
    end

    // Receive state machine
    if (!recvOn) begin
      next_cur.state   = IDLE;
      next_cur.overrun = 1'b0;
      next_cur.tickCnt = 4'h0;
    end else if (tick) begin
      next_cur.tickCnt = cur.tickCnt + 4'h1;
      unique case (cur.state)
        IDLE: begin
          next_cur.tickCnt = 4'h0;
          if (!cur.rxLevel && !cur.overrun) begin
            next_cur.state = START;
          end
        end
        START: begin
          if (cur.tickCnt == `MID_SAMPLE) begin
            next_cur.tickCnt = 4'h0;
            next_cur.bitCnt  = 4'h0;
            next_cur.state   = cur.rxLevel ? IDLE : DATA;
          end
        end
        DATA: begin
          if (cur.tickCnt == 4'hf) begin
            next_cur.shiftReg = {cur.rxLevel, cur.shiftReg[8:1]};
            next_cur.bitCnt   = cur.bitCnt + 4'h1;
            if (cur.bitCnt == (ninthOn ? 4'h8 : 4'h7)) begin
              next_cur.state = STOP;
            end
          end
        end
        STOP: begin
          if (cur.tickCnt == 4'hf) begin
            stopEvent      = 1'b1;
            next_cur.state = IDLE;
          end
        end
      endcase
    end

    // Queue: pop on data read, push on completed frame
    if (popReq) begin
      next_cur.queue[0] = cur.queue[1];
      next_cur.count    = cur.count - 2'h1;
    end
    if (stopEvent) begin
      isAddr = !ninthOn || !cur.rcCtrl[`BIT_ADDRESS_DETECT_EN] || cur.shiftReg[8] == 1'b1;
      if (isAddr && !cur.overrun) begin
        if (cur.count == 2'h2 && !popReq) begin
          next_cur.overrun = 1'b1;
        end else begin
          accept = 1'b1;
          next_cur.queue[next_cur.count[0]].data    = ninthOn ? cur.shiftReg
                                                               : {1'b0, cur.shiftReg[8:1]};
          next_cur.queue[next_cur.count[0]].framing = !cur.rxLevel;
          next_cur.count = next_cur.count + 2'h1;
        end
      end
    end

    // Register writes
    if (wrStrobe) begin
      unique case (addr)
        `ADDR_INTERRUPT_CONTROL:   next_cur.intCtrl = wrData;
        `ADDR_RECEIVE_STATUS_CTRL: next_cur.rcCtrl  = {wrData[7:3], 3'h0};
        `ADDR_TRANSMIT_DATA:       next_cur.txData  = wrData;
        `ADDR_PERIPHERAL_ENABLES:  next_cur.pie     = wrData;
        `ADDR_TRANSMIT_STATUS:     next_cur.txStatus = {wrData[7:4], 1'b0, wrData[2], cur.txStatus[1], wrData[0]};
        `ADDR_BAUD_DIVISOR:        next_cur.baud    = wrData;
        default: ;
      endcase
    end

    // Register reads, status shows head of queue
    status = {cur.rcCtrl[7:3], head.framing & (cur.count != 2'h0), cur.overrun,
              head.data[8] & (cur.count != 2'h0)};
    next_cur.rdData = 8'h00;
    if (rdStrobe) begin
      unique case (addr)
        `ADDR_INTERRUPT_CONTROL:   next_cur.rdData = cur.intCtrl;
        `ADDR_PERIPHERAL_FLAGS:    next_cur.rdData = {2'h0, cur.count != 2'h0, 5'h00};
        `ADDR_RECEIVE_STATUS_CTRL: next_cur.rdData = status;
        `ADDR_TRANSMIT_DATA:       next_cur.rdData = cur.txData;
        `ADDR_RECEIVE_DATA:        next_cur.rdData = cur.count != 2'h0 ? head.data[7:0] : 8'h00;
        `ADDR_PERIPHERAL_ENABLES:  next_cur.rdData = cur.pie;
        `ADDR_TRANSMIT_STATUS:     next_cur.rdData = cur.txStatus;
        `ADDR_BAUD_DIVISOR:        next_cur.rdData = cur.baud;
        default:                   next_cur.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur          <= '0;
      cur.txStatus <= `RESET_TRANSMIT_STATUS;
      cur.rxSync   <= 3'h7;
      cur.rxLevel  <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // Assertions
  sequence stopSeen;
    stopEvent && !cur.overrun
    && (!cur.rcCtrl[`BIT_NINE_BIT_EN] || !cur.rcCtrl[`BIT_ADDRESS_DETECT_EN] || cur.shiftReg[8]);
  endsequence

  sequence fullBuffer;
    cur.count == 2'h2 && !popReq;
  endsequence

  flag_readonly_a: assert property (@(posedge sys_clk) disable iff (rst)
    cur.count != 2'h0 && !popReq |=> cur.count != 2'h0)
    else $error("receive flag cleared while buffer not emptied");

  overrun_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    stopSeen ##0 fullBuffer |-> !accept ##1 (cur.overrun || !recvOn))
    else $error("overrun not raised on full buffer");

  overrun_block_a: assert property (@(posedge sys_clk) disable iff (rst)
    cur.overrun |-> !accept)
    else $error("transfer while overrun set");

  overrun_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    cur.overrun && recvOn |=> cur.overrun)
    else $error("overrun cleared without receive reset");

  disable_clears_a: assert property (@(posedge sys_clk) disable iff (rst)
    !recvOn |=> !cur.overrun && cur.state == IDLE)
    else $error("receiver not reset when disabled");

  push_count_a: assert property (@(posedge sys_clk) disable iff (rst)
    accept && !popReq |=> cur.count == $past(cur.count) + 2'h1)
    else $error("accepted word not queued");

  irq_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    irq |-> cur.pie[`BIT_RECEIVE_FLAG] && cur.count != 2'h0)
    else $error("interrupt without enabled flag");

  fifo_order_a: assert property (@(posedge sys_clk) disable iff (rst)
    popReq && cur.count == 2'h2 && !accept |=> cur.queue[0] == $past(cur.queue[1]))
    else $error("queue did not advance oldest first");

  addr_filter_a: assert property (@(posedge sys_clk) disable iff (rst)
    stopEvent && cur.rcCtrl[`BIT_NINE_BIT_EN] && cur.rcCtrl[`BIT_ADDRESS_DETECT_EN]
    && !cur.shiftReg[8] |-> !accept)
    else $error("data byte admitted in address detect");

  async_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    !recvOn |-> cur.state == IDLE || $past(recvOn))
    else $error("receiver active while disabled");

  bus_count_a: assert property (@(posedge sys_clk) disable iff (rst)
    cur.count <= 2'h2)
    else $error("queue count out of range");

  // Read port checks
  sequence statusRead;
    rdStrobe && addr == `ADDR_RECEIVE_STATUS_CTRL;
  endsequence

  sequence flagRead;
    rdStrobe && addr == `ADDR_PERIPHERAL_FLAGS;
  endsequence

  sequence dataRead;
    popReq;
  endsequence

  flag_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    flagRead |=> rdData[`BIT_RECEIVE_FLAG] == ($past(cur.count) != 2'h0))
    else $error("receive flag read wrong");

  flag_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    cur.count == 2'h1 && popReq && !accept |=> cur.count == 2'h0)
    else $error("receive flag not cleared when emptied");

  data_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    dataRead |=> rdData == $past(head.data[7:0]))
    else $error("data read not oldest word");

  status_ninth_a: assert property (@(posedge sys_clk) disable iff (rst)
    statusRead ##0 cur.count != 2'h0
    |=> rdData[`BIT_RECEIVED_NINTH] == $past(head.data[8]))
    else $error("ninth bit not of head word");

  status_frame_a: assert property (@(posedge sys_clk) disable iff (rst)
    statusRead ##0 cur.count != 2'h0
    |=> rdData[`BIT_FRAMING_ERROR] == $past(head.framing))
    else $error("framing bit not of head word");

  status_overrun_a: assert property (@(posedge sys_clk) disable iff (rst)
    statusRead |=> rdData[`BIT_OVERRUN_ERROR] == $past(cur.overrun))
    else $error("overrun bit read wrong");

  // Receive path checks
  sequence firstLanding;
    accept && cur.count == 2'h0 && !popReq;
  endsequence

  sequence secondLanding;
    accept && cur.count == 2'h1 && !popReq;
  endsequence

  frame_queued_a: assert property (@(posedge sys_clk) disable iff (rst)
    firstLanding |=> cur.queue[0].framing == !$past(cur.rxLevel))
    else $error("framing error not queued");

  eight_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
    firstLanding ##0 !cur.rcCtrl[`BIT_NINE_BIT_EN]
    |=> cur.queue[0].data == {1'b0, $past(cur.shiftReg[8:1])})
    else $error("eight bit word queued wrong");

  ninth_capture_a: assert property (@(posedge sys_clk) disable iff (rst)
    firstLanding ##0 cur.rcCtrl[`BIT_NINE_BIT_EN] |=> cur.queue[0].data == $past(cur.shiftReg))
    else $error("nine bit word queued wrong");

  second_push_a: assert property (@(posedge sys_clk) disable iff (rst)
    secondLanding ##0 !cur.rcCtrl[`BIT_NINE_BIT_EN]
    |=> cur.queue[1].data[7:0] == $past(cur.shiftReg[8:1]))
    else $error("second word not behind first");

  queue_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
    !accept && !popReq |=> $stable(cur.count))
    else $error("queue count moved without event");

  addr_admit_a: assert property (@(posedge sys_clk) disable iff (rst)
    stopEvent && !cur.overrun && cur.shiftReg[8] && cur.count != 2'h2 |-> accept)
    else $error("address byte not loaded");

  plain_admit_a: assert property (@(posedge sys_clk) disable iff (rst)
    stopEvent && !cur.overrun && !cur.rcCtrl[`BIT_ADDRESS_DETECT_EN] && cur.count != 2'h2 |-> accept)
    else $error("byte refused without address detect");

  overrun_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    cur.overrun |-> cur.state == IDLE)
    else $error("frame search while overrun set");

  stop_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    stopEvent |=> cur.state == IDLE)
    else $error("receiver not idle after stop");

  start_reject_a: assert property (@(posedge sys_clk) disable iff (rst)
    cur.state == START && tick && cur.tickCnt == `MID_SAMPLE && cur.rxLevel |=> cur.state == IDLE)
    else $error("false start bit accepted");

  // Interrupt and timing checks
  irq_raise_a: assert property (@(posedge sys_clk) disable iff (rst)
    cur.count != 2'h0 && cur.pie[`BIT_RECEIVE_FLAG]
    && cur.intCtrl[`BIT_GLOBAL_IE] && cur.intCtrl[`BIT_PERIPH_IE] |-> irq)
    else $error("interrupt missing");

  irq_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
    !cur.pie[`BIT_RECEIVE_FLAG] |-> !irq)
    else $error("interrupt while disabled");

  tick_space_a: assert property (@(posedge sys_clk) disable iff (rst)
    tick && cur.baud != 8'h00 |=> !tick)
    else $error("sample ticks too close");

  tick_reload_a: assert property (@(posedge sys_clk) disable iff (rst)
    tick |=> cur.baudCnt == $past(cur.baud))
    else $error("divider not reloaded");

  shift_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !tick |=> $stable(cur.shiftReg))
    else $error("shift register moved off tick");

  tick_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    !asyncOn |-> !tick)
    else $error("sampling outside asynchronous mode");

  disabled_tick_a: assert property (@(posedge sys_clk) disable iff (rst)
    !cur.rcCtrl[`BIT_CONT_RECEIVE_EN] |-> !tick)
    else $error("sampling without receive enable");
endmodule : async_serial_receiver
`default_nettype wire

//--- src/serial_rx_defines.svh
// Register offsets, field positions, reset values and timing counts for the serial receiver.
// Assumes inclusion by the receiver module only; the package does not include it.
`ifndef SERIAL_RX_DEFINES_SVH
`define SERIAL_RX_DEFINES_SVH
`define ADDR_INTERRUPT_CONTROL   8'h0b
`define ADDR_PERIPHERAL_FLAGS    8'h0c
`define ADDR_RECEIVE_STATUS_CTRL 8'h18
`define ADDR_TRANSMIT_DATA       8'h19
`define ADDR_RECEIVE_DATA        8'h1a
`define ADDR_PERIPHERAL_ENABLES  8'h8c
`define ADDR_TRANSMIT_STATUS     8'h98
`define ADDR_BAUD_DIVISOR        8'h99
`define BIT_GLOBAL_IE            7
`define BIT_PERIPH_IE            6
`define BIT_RECEIVE_FLAG         5
`define BIT_SERIAL_PORT_EN       7
`define BIT_NINE_BIT_EN          6
`define BIT_CONT_RECEIVE_EN      4
`define BIT_ADDRESS_DETECT_EN    3
`define BIT_FRAMING_ERROR        2
`define BIT_OVERRUN_ERROR        1
`define BIT_RECEIVED_NINTH       0
`define BIT_SYNC_MODE            4
`define BIT_HIGH_BAUD            2
`define RESET_TRANSMIT_STATUS    8'h02
`define RESET_ZERO               8'h00
`define OVERSAMPLE               16
`define MID_SAMPLE               4'h7
`endif

//--- src/serial_rx_pkg.sv
// Types shared by the serial receiver.
// Assumes nothing from the defines header.
`default_nettype none
package serial_rx_pkg;
  typedef enum logic [1:0] {IDLE, START, DATA, STOP} rx_state_t;
  typedef logic [7:0] reg_byte_t;
  typedef struct packed {
    logic [8:0] data;
    logic       framing;
  } rx_entry_t;
endpackage : serial_rx_pkg
`default_nettype wire

//--- testbench/serial_line_driver.sv
// Remote asynchronous transmitter model on the receive line.
// Assumes the same clock as the receiver; bit time is BIT_CYCLES.
`default_nettype none
module serial_line_driver #(
  parameter int BIT_CYCLES = 32
) (
  input  wire logic sysClk,
  output var  logic rxLine
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxLine = 1'b1;
  task automatic hold(input int n);
    repeat (n) @(posedge sysClk);
  endtask : hold
  // Start, data LSB first, optional ninth bit, stop, then idle high
  task automatic send(input logic [7:0] d, input logic useNine, input logic nine, input logic stopOk);
    int i;
    rxLine <= 1'b0;
    hold(BIT_CYCLES);
    for (i = 0; i < 8; i++) begin
      rxLine <= d[i];
      hold(BIT_CYCLES);
    end
    if (useNine) begin
      rxLine <= nine;
      hold(BIT_CYCLES);
    end
    rxLine <= stopOk;
    hold(stopOk ? BIT_CYCLES : BIT_CYCLES * 3 / 4);
    rxLine <= 1'b1;
    hold(BIT_CYCLES);
  endtask : send
endmodule : serial_line_driver
`default_nettype wire

//--- testbench/async_serial_receiver_tb.sv
// Self-checking bench: register reads are queued and checked by a monitor.
// Assumes the design and the line driver model are compiled first.
`default_nettype none
module async_serial_receiver_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CYCLES = 32;
  localparam int LIMIT = 20000;
  logic        sysClk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wrData = 8'h00;
  logic        wrStrobe = 1'b0;
  logic        rdStrobe = 1'b0;
  logic        rdPend = 1'b0;
  logic [7:0]  rdData;
  logic        rxLine;
  logic        irq;
  logic [15:0] expQ [$];
  logic [15:0] note;
  logic [31:0] seed = 32'h10f7b21c;
  logic [7:0]  b [4];
  logic [7:0]  regAddr [8] = '{8'h0b, 8'h0c, 8'h18, 8'h19, 8'h1a, 8'h8c, 8'h98, 8'h99};
  int          badCount = 0;
  int          nCompared = 0;
  int          cycles = 0;
  always #25 sysClk = ~sysClk;
  async_serial_receiver u_async_serial_receiver (.sys_clk(sysClk), .rst(rst), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .rxPin(rxLine), .irq(irq));
  serial_line_driver #(.BIT_CYCLES(BIT_CYCLES)) u_serial_line_driver (.sysClk(sysClk), .rxLine(rxLine));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic cmp(input string name, input logic [7:0] e, input logic [7:0] s);
    nCompared++;
    if (s !== e) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", name, e, s);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge sysClk);
    wrStrobe <= 1'b0;
    @(posedge sysClk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rdStrobe <= 1'b1;
    expQ.push_back({a, e});
    @(posedge sysClk);
    rdStrobe <= 1'b0;
    @(posedge sysClk);
  endtask : rd
  task automatic tx(input logic [7:0] d, input logic useNine, input logic nine, input logic stopOk);
    u_serial_line_driver.send(d, useNine, nine, stopOk);
  endtask : tx
  task automatic finishTest();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finishTest
  // Read data monitor
  always @(posedge sysClk) begin
    if (rdPend) begin
      note = expQ.pop_front();
      cmp($sformatf("rdData at %h", note[15:8]), note[7:0], rdData);
    end
    rdPend <= rdStrobe;
  end
  always @(posedge sysClk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      badCount++;
      finishTest();
    end
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      b[i] = seed[7:0];
    end
    repeat (4) @(posedge sysClk);
    rst <= 1'b0;
    @(posedge sysClk);
    wr(8'h0c, 8'hff);
    wr(8'h1a, 8'hff);
    foreach (regAddr[i]) rd(regAddr[i], (regAddr[i] == 8'h98) ? 8'h02 : 8'h00);
    rd(8'h20, 8'h00);
    $display("test reset done");
    wr(8'h99, 8'h01);
    wr(8'h98, 8'h00);
    wr(8'h8c, 8'h20);
    rd(8'h8c, 8'h20);
    wr(8'h0b, 8'hc0);
    wr(8'h18, 8'h80);
    tx(b[3], 1'b0, 1'b0, 1'b1);
    rd(8'h0c, 8'h00);
    wr(8'h18, 8'h90);
    tx(b[0], 1'b0, 1'b0, 1'b1);
    cmp("irq", 8'h01, {7'h00, irq});
    wr(8'h8c, 8'h00);
    cmp("irq", 8'h00, {7'h00, irq});
    wr(8'h8c, 8'h20);
    rd(8'h0c, 8'h20);
    rd(8'h1a, b[0]);
    rd(8'h0c, 8'h00);
    cmp("irq", 8'h00, {7'h00, irq});
    $display("test single frame done");
    for (int i = 0; i < 3; i++) tx(b[i], 1'b0, 1'b0, 1'b1);
    rd(8'h18, 8'h92);
    rd(8'h1a, b[0]);
    rd(8'h1a, b[1]);
    tx(b[3], 1'b0, 1'b0, 1'b1);
    rd(8'h0c, 8'h00);
    wr(8'h18, 8'h80);
    wr(8'h18, 8'h90);
    rd(8'h18, 8'h90);
    $display("test overrun done");
    wr(8'h18, 8'hd0);
    tx(b[1], 1'b1, 1'b1, 1'b0);
    tx(b[2], 1'b1, 1'b0, 1'b1);
    rd(8'h18, 8'hd5);
    rd(8'h1a, b[1]);
    rd(8'h18, 8'hd0);
    rd(8'h1a, b[2]);
    $display("test nine bit done");
    wr(8'h18, 8'hd8);
    tx(b[3], 1'b1, 1'b0, 1'b1);
    rd(8'h0c, 8'h00);
    tx(b[0], 1'b1, 1'b1, 1'b1);
    rd(8'h18, 8'hd9);
    rd(8'h1a, b[0]);
    wr(8'h18, 8'hd0);
    tx(b[1], 1'b1, 1'b0, 1'b1);
    rd(8'h18, 8'hd0);
    rd(8'h1a, b[1]);
    $display("test address detect done");
    repeat (3) @(posedge sysClk);
    finishTest();
  end
endmodule : async_serial_receiver_tb
`default_nettype wire
